//--- flash_cfg_pkg.sv
// Purpose: shared constants for the flash configuration register logic
// Assumes: one serial link, single-line command input, single-line output
// Notes: opcodes are local choices, see hand-over
package flash_cfg_pkg;
  // ****************************************
  // commands
  // ****************************************
  localparam logic [7:0] OP_RD_NV = 8'hB5;
  localparam logic [7:0] OP_WR_NV = 8'hB1;
  localparam logic [7:0] OP_RD_VOL = 8'h85;
  localparam logic [7:0] OP_WR_VOL = 8'h81;
  localparam int OP_LAST_BIT = 7;
  localparam int NV_LAST_BIT = 15;
  localparam int VOL_LAST_BIT = 7;
  // ****************************************
  // persistent_setup fields
  // ****************************************
  localparam int NV_W = 16;
  localparam int NV_DUMMY_LSB = 12;
  localparam int NV_XIP_LSB = 9;
  localparam int NV_DRV_LSB = 6;
  localparam int NV_DTR_BIT = 5;
  localparam int NV_HOLD_BIT = 4;
  localparam int NV_QUAD_BIT = 3;
  localparam int NV_DUAL_BIT = 2;
  localparam int NV_SEG_BIT = 1;
  localparam int NV_ADDR_BIT = 0;
  localparam logic [15:0] NV_RESET = 16'hFFFF;
  // ****************************************
  // runtime_setup fields
  // ****************************************
  localparam int VOL_W = 8;
  localparam int VOL_DUMMY_LSB = 4;
  localparam int VOL_XIP_BIT = 3;
  localparam int VOL_RSVD_BIT = 2;
  localparam int VOL_WRAP_LSB = 0;
  localparam logic [7:0] VOL_RESET = 8'hFB;
  // ****************************************
  // codes and address layout
  // ****************************************
  localparam logic [3:0] DUMMY_DFLT_LO = 4'h0;
  localparam logic [3:0] DUMMY_DFLT_HI = 4'hF;
  localparam logic [2:0] XIP_OFF = 3'h7;
  localparam logic [2:0] XIP_LAST_MODE = 3'h4;
  localparam logic [1:0] WRAP_16 = 2'h0;
  localparam logic [1:0] WRAP_32 = 2'h1;
  localparam logic [1:0] WRAP_CONT = 2'h3;
  localparam logic [5:0] MASK_16 = 6'h0F;
  localparam logic [5:0] MASK_32 = 6'h1F;
  localparam logic [5:0] MASK_64 = 6'h3F;
  localparam logic [2:0] SEG_LOWEST = 3'h0;
  localparam logic [2:0] SEG_HIGHEST = 3'h7;
  localparam int ADDR_W = 27;
  localparam int SEG_LSB = 24;
  localparam int WRAP_BITS = 6;
  typedef enum logic [1:0] {L_CMD, L_WDATA, L_RDATA, L_IDLE} link_state_t;
endpackage : flash_cfg_pkg

//--- cfg_sync2.sv
// Purpose: two-flop synchroniser for levels
// Assumes: multi-bit use only for data that is static while sampled
// Notes: first stage feeds only the second
module cfg_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk, // destination clock
  input wire logic i_nrst, // async reset, active low
  input wire logic [W-1:0] i_d, // foreign level
  output logic [W-1:0] o_q // synchronised level
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : cfg_sync2

//--- cfg_serial_port.sv
// Purpose: serial command front end on the link clock
// Assumes: mode 0 link, command and data msb first on one line
// Notes: write data is held until the next write, so a toggle suffices
module cfg_serial_port
  import flash_cfg_pkg::*;
(
  input wire logic i_sclk, // link clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_cs_n, // frame select, active low
  input wire logic i_dq0, // serial data in
  input wire logic [flash_cfg_pkg::NV_W-1:0] i_nv_snap, // core persistent value
  input wire logic [flash_cfg_pkg::VOL_W-1:0] i_vol_snap, // core runtime value
  output logic o_dq1, // serial data out
  output logic o_dq1_oe, // out enable, high while driving
  output logic o_wr_toggle, // flips once per finished write
  output logic o_wr_is_nv, // finished write was persistent
  output logic [flash_cfg_pkg::NV_W-1:0] o_wr_data // write value, vol in low byte
);
  import flash_cfg_pkg::*;
  // ****************************************
  // frame state, cleared whenever select is high
  // ****************************************
  link_state_t st_reg;
  logic [4:0] cnt_reg;
  logic wnv_reg;
  logic [15:0] in_reg;
  logic [15:0] out_reg;
  logic [23:0] snap;
  wire frame_rst_n = i_nrst & ~i_cs_n;
  wire [7:0] opc = {in_reg[6:0], i_dq0};
  wire [15:0] wval = {in_reg[14:0], i_dq0};
  wire op_done = (st_reg == L_CMD) && (cnt_reg == 5'(OP_LAST_BIT));
  wire [4:0] wlast = wnv_reg ? 5'(NV_LAST_BIT) : 5'(VOL_LAST_BIT);
  wire wr_done = (st_reg == L_WDATA) && (cnt_reg == wlast);
  // register values only move on writes or resets, never mid-frame
  cfg_sync2 #(.W(24)) u_snap (
    .i_clk(i_sclk),
    .i_nrst(i_nrst),
    .i_d({i_nv_snap, i_vol_snap}),
    .o_q(snap)
  );
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_reg <= L_CMD;
      cnt_reg <= 5'h0;
      wnv_reg <= 1'b0;
      in_reg <= 16'h0;
      out_reg <= 16'h0;
    end else begin
      in_reg <= wval;
      cnt_reg <= (op_done || wr_done) ? 5'h0 : cnt_reg + 5'h1;
      out_reg <= {out_reg[14:0], 1'b0};
      if (op_done) begin
        st_reg <= L_IDLE;
        wnv_reg <= (opc == OP_WR_NV);
        if (opc == OP_WR_NV || opc == OP_WR_VOL) st_reg <= L_WDATA;
        if (opc == OP_RD_NV) begin
          st_reg <= L_RDATA;
          out_reg <= snap[23:8];
        end
        if (opc == OP_RD_VOL) begin
          st_reg <= L_RDATA;
          out_reg <= {snap[7:0], 8'h0};
        end
      end else if (wr_done) begin
        st_reg <= L_IDLE;
      end
    end
  end
  // write commit survives the end of the frame
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr_toggle <= 1'b0;
      o_wr_is_nv <= 1'b0;
      o_wr_data <= 16'h0;
    end else if (wr_done) begin
      o_wr_toggle <= ~o_wr_toggle;
      o_wr_is_nv <= wnv_reg;
      o_wr_data <= wval;
    end
  end
  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      o_dq1 <= 1'b0;
      o_dq1_oe <= 1'b0;
    end else begin
      o_dq1 <= out_reg[15];
      o_dq1_oe <= (st_reg == L_RDATA);
    end
  end
endmodule : cfg_serial_port

//--- flash_config_registers.sv
// Purpose: persistent and runtime configuration registers of a serial flash
// Assumes: i_por_n marks power loss, i_nrst marks any device reset
// Notes: both resets assert together at power-up
module flash_config_registers
  import flash_cfg_pkg::*;
#(
  parameter logic [3:0] DFLT_DUMMY = 4'h8
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_nrst, // device reset, active low
  input wire logic i_por_n, // power-on reset, active low
  input wire logic i_sclk, // serial link clock
  input wire logic i_cs_n, // link select, active low
  input wire logic i_dq0, // link data in
  output logic o_dq1, // link data out
  output logic o_dq1_oe, // link out enable
  input wire logic i_rd_start, // read begins, pulse
  input wire logic [flash_cfg_pkg::ADDR_W-1:0] i_rd_addr, // issued address
  input wire logic i_rd_next, // one byte delivered, pulse
  output logic [flash_cfg_pkg::ADDR_W-1:0] o_rd_addr, // current read address
  output logic [3:0] o_dummy_cycles, // dummy clocks for quick reads
  output logic o_dummy_default, // command default count applies
  output logic o_xip_active, // execute_in_place on
  output logic [2:0] o_xip_mode, // execute_in_place read kind
  output logic [2:0] o_drive_code, // output impedance code
  output logic o_drive_valid, // impedance code is not reserved
  output logic o_dtr_en, // double transfer rate
  output logic o_data_line_three_hold_en, // hold/reset on data_line_three
  output logic o_quad_proto, // four-line command protocol
  output logic o_dual_proto, // two-line command protocol
  output logic o_addr_4byte, // four-byte addresses
  output logic [2:0] o_segment, // segment for three-byte mode
  output logic [flash_cfg_pkg::NV_W-1:0] o_nv_value, // persistent_setup
  output logic [flash_cfg_pkg::VOL_W-1:0] o_vol_value // runtime_setup
);
  import flash_cfg_pkg::*;
  // ****************************************
  // link side and crossing
  // ****************************************
  logic wr_toggle;
  logic wr_is_nv;
  logic [15:0] wr_data;
  logic tog_sync;
  logic tog_seen_reg;
  logic [15:0] nv_reg;
  logic [7:0] vol_reg;
  cfg_serial_port u_port (
    .i_sclk(i_sclk),
    .i_nrst(i_nrst),
    .i_cs_n(i_cs_n),
    .i_dq0(i_dq0),
    .i_nv_snap(nv_reg),
    .i_vol_snap(vol_reg),
    .o_dq1(o_dq1),
    .o_dq1_oe(o_dq1_oe),
    .o_wr_toggle(wr_toggle),
    .o_wr_is_nv(wr_is_nv),
    .o_wr_data(wr_data)
  );
  cfg_sync2 #(.W(1)) u_tog (
    .i_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d(wr_toggle),
    .o_q(tog_sync)
  );
  wire wr_pulse = tog_sync ^ tog_seen_reg;
  wire nv_wr = wr_pulse && wr_is_nv;
  wire vol_wr = wr_pulse && !wr_is_nv;
  // ****************************************
  // registers and working settings
  // ****************************************
  logic reload_reg;
  logic [2:0] xip_mode_reg;
  logic [2:0] drv_reg;
  logic dtr_n_reg;
  logic hold_reg;
  logic quad_n_reg;
  logic dual_n_reg;
  logic addr3_reg;
  logic [2:0] seg_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  wire [2:0] nv_xip = nv_reg[NV_XIP_LSB +: 3];
  wire nv_xip_on = nv_xip <= XIP_LAST_MODE;
  wire [7:0] vol_from_nv = {nv_reg[NV_DUMMY_LSB +: 4], !nv_xip_on, 1'b0, WRAP_CONT};
  wire [7:0] vol_from_wr = {wr_data[7:3], 1'b0, wr_data[1:0]};
  // persistent storage only forgets on power loss
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      nv_reg <= NV_RESET;
    end else if (nv_wr) begin
      nv_reg <= wr_data;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tog_seen_reg <= 1'b0;
      reload_reg <= 1'b1;
    end else begin
      tog_seen_reg <= tog_sync;
      reload_reg <= 1'b0;
    end
  end
  // async reset loads constants; the copy from storage follows one edge later
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vol_reg <= VOL_RESET;
      xip_mode_reg <= XIP_OFF;
      drv_reg <= NV_RESET[NV_DRV_LSB +: 3];
      dtr_n_reg <= 1'b1;
      hold_reg <= 1'b1;
      quad_n_reg <= 1'b1;
      dual_n_reg <= 1'b1;
      addr3_reg <= 1'b1;
      seg_reg <= SEG_LOWEST;
    end else if (reload_reg) begin
      vol_reg <= vol_from_nv;
      xip_mode_reg <= nv_xip;
      drv_reg <= nv_reg[NV_DRV_LSB +: 3];
      dtr_n_reg <= nv_reg[NV_DTR_BIT];
      hold_reg <= nv_reg[NV_HOLD_BIT];
      quad_n_reg <= nv_reg[NV_QUAD_BIT];
      dual_n_reg <= nv_reg[NV_DUAL_BIT];
      addr3_reg <= nv_reg[NV_ADDR_BIT];
      seg_reg <= nv_reg[NV_SEG_BIT] ? SEG_LOWEST : SEG_HIGHEST;
    end else if (vol_wr) begin
      vol_reg <= vol_from_wr;
    end
  end
  // ****************************************
  // decoded settings
  // ****************************************
  wire [3:0] dcode = vol_reg[VOL_DUMMY_LSB +: 4];
  wire dflt = (dcode == DUMMY_DFLT_LO) || (dcode == DUMMY_DFLT_HI);
  assign o_dummy_default = dflt;
  assign o_dummy_cycles = dflt ? DFLT_DUMMY : dcode;
  assign o_xip_active = !vol_reg[VOL_XIP_BIT];
  // a runtime enable with no stored mode falls back to plain quick read
  assign o_xip_mode = (xip_mode_reg <= XIP_LAST_MODE) ? xip_mode_reg : 3'h0;
  assign o_drive_code = drv_reg;
  assign o_drive_valid = drv_reg[0];
  assign o_dtr_en = !dtr_n_reg;
  assign o_data_line_three_hold_en = hold_reg;
  assign o_quad_proto = !quad_n_reg;
  assign o_dual_proto = !dual_n_reg && quad_n_reg;
  assign o_addr_4byte = !addr3_reg;
  assign o_segment = seg_reg;
  assign o_nv_value = nv_reg;
  assign o_vol_value = vol_reg;
  // ****************************************
  // read address sequencing
  // ****************************************
  wire [1:0] wrap = vol_reg[VOL_WRAP_LSB +: 2];
  wire wrap_cont = wrap == WRAP_CONT;
  wire [5:0] mask6 = (wrap == WRAP_16) ? MASK_16 : (wrap == WRAP_32) ? MASK_32 : MASK_64;
  wire [ADDR_W-1:0] mask = {{(ADDR_W - WRAP_BITS){1'b0}}, mask6};
  wire [ADDR_W-1:0] inc = rd_addr_reg + 27'h1;
  wire [ADDR_W-1:0] start = o_addr_4byte ? i_rd_addr :
                            {seg_reg, i_rd_addr[SEG_LSB-1:0]};
  wire [ADDR_W-1:0] step = wrap_cont ? inc :
                           ((rd_addr_reg & ~mask) | (inc & mask));
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_addr_reg <= '0;
    end else if (i_rd_start) begin
      rd_addr_reg <= start;
    end else if (i_rd_next) begin
      rd_addr_reg <= step;
    end
  end
  assign o_rd_addr = rd_addr_reg;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_reload_addr_len: assert property (reload_reg |=>
    o_addr_4byte == !$past(nv_reg[NV_ADDR_BIT]))
    else $error("address length not loaded from storage");
  a_reload_segment: assert property (reload_reg |=>
    o_segment == ($past(nv_reg[NV_SEG_BIT]) ? SEG_LOWEST : SEG_HIGHEST))
    else $error("segment not loaded from storage");
  a_reload_xip_dtr: assert property (reload_reg |=>
    o_xip_active == ($past(nv_xip) <= XIP_LAST_MODE) && o_dtr_en == !$past(nv_reg[NV_DTR_BIT]))
    else $error("execute_in_place or rate not loaded");
  a_vol_write_load: assert property (vol_wr && !reload_reg |=>
    o_vol_value == {$past(wr_data[7:3]), 1'b0, $past(wr_data[1:0])})
    else $error("runtime write not applied");
  a_nv_write_quiet: assert property (nv_wr && !reload_reg |=>
    $stable(o_dtr_en) && $stable(o_addr_4byte) && $stable(o_quad_proto))
    else $error("persistent write changed working settings");
  a_vol_reserved: assert property (!o_vol_value[VOL_RSVD_BIT])
    else $error("reserved runtime bit set");
  a_quad_priority: assert property (!quad_n_reg |-> o_quad_proto && !o_dual_proto)
    else $error("two-line protocol chosen over four-line");
  a_dummy_map: assert property (vol_wr && !reload_reg ##1 !o_dummy_default |->
    o_dummy_cycles == $past(wr_data[7:4]))
    else $error("dummy count mismatch");
  a_wrap_block: assert property (i_rd_next && !i_rd_start && !wrap_cont |=>
    o_rd_addr[ADDR_W-1:WRAP_BITS] == $past(o_rd_addr[ADDR_W-1:WRAP_BITS]))
    else $error("wrapped read left its block");
  a_wrap_cont: assert property (i_rd_next && !i_rd_start && wrap_cont |=>
    o_rd_addr == $past(o_rd_addr) + 27'h1)
    else $error("continuous read did not increment");
  a_wrap_16_step: assert property (i_rd_next && !i_rd_start &&
    wrap == WRAP_16 |=>
    o_rd_addr[3:0] == $past(o_rd_addr[3:0]) + 4'h1 &&
    o_rd_addr[ADDR_W-1:4] == $past(o_rd_addr[ADDR_W-1:4]))
    else $error("16-byte wrap step wrong");
  a_wrap_32_step: assert property (i_rd_next && !i_rd_start &&
    wrap == WRAP_32 |=>
    o_rd_addr[4:0] == $past(o_rd_addr[4:0]) + 5'h1 &&
    o_rd_addr[ADDR_W-1:5] == $past(o_rd_addr[ADDR_W-1:5]))
    else $error("32-byte wrap step wrong");
  a_wrap_64_step: assert property (i_rd_next && !i_rd_start &&
    !wrap_cont && mask6 == MASK_64 |=>
    o_rd_addr[5:0] == $past(o_rd_addr[5:0]) + 6'h1 &&
    o_rd_addr[ADDR_W-1:6] == $past(o_rd_addr[ADDR_W-1:6]))
    else $error("64-byte wrap step wrong");
  a_start_segment: assert property (i_rd_start && !o_addr_4byte |=>
    o_rd_addr[ADDR_W-1:SEG_LSB] == $past(o_segment) &&
    o_rd_addr[SEG_LSB-1:0] == $past(i_rd_addr[SEG_LSB-1:0]))
    else $error("three-byte start address not formed from segment");
  a_start_full: assert property (i_rd_start && o_addr_4byte |=>
    o_rd_addr == $past(i_rd_addr))
    else $error("four-byte start address not taken whole");
  a_addr_hold: assert property (!i_rd_start && !i_rd_next |=>
    $stable(o_rd_addr))
    else $error("read address moved without a request");
  // ****************************************
  // checks on settings and reload
  // ****************************************
  a_dummy_field: assert property (!o_dummy_default |->
    o_dummy_cycles == o_vol_value[VOL_DUMMY_LSB +: 4])
    else $error("dummy count differs from runtime field");
  a_dummy_range: assert property (!o_dummy_default |->
    o_dummy_cycles != DUMMY_DFLT_LO && o_dummy_cycles != DUMMY_DFLT_HI)
    else $error("default code reported as a count");
  a_dummy_fallback: assert property (o_dummy_default |->
    o_dummy_cycles == DFLT_DUMMY)
    else $error("default dummy count not applied");
  a_xip_follow: assert property (
    o_xip_active == !o_vol_value[VOL_XIP_BIT])
    else $error("execute_in_place enable differs from runtime bit");
  a_drive_reserved: assert property (
    o_drive_valid == o_drive_code[0])
    else $error("reserved impedance code reported valid");
  a_dual_excl: assert property (o_dual_proto |->
    !o_quad_proto)
    else $error("two-line and four-line protocol both on");
  a_reload_dummy: assert property (reload_reg |=>
    o_vol_value[VOL_DUMMY_LSB +: 4] == $past(nv_reg[NV_DUMMY_LSB +: 4]))
    else $error("dummy field not loaded from storage");
  a_reload_mode: assert property (reload_reg |=>
    o_xip_mode == (($past(nv_xip) <= XIP_LAST_MODE) ? $past(nv_xip) : 3'h0))
    else $error("execute_in_place mode not loaded");
  a_reload_drive: assert property (reload_reg |=>
    o_drive_code == $past(nv_reg[NV_DRV_LSB +: 3]))
    else $error("impedance code not loaded");
  a_reload_hold: assert property (reload_reg |=>
    o_data_line_three_hold_en == $past(nv_reg[NV_HOLD_BIT]))
    else $error("hold function not loaded");
  a_reload_quad: assert property (reload_reg |=>
    o_quad_proto == !$past(nv_reg[NV_QUAD_BIT]))
    else $error("four-line protocol not loaded");
  a_reload_dual: assert property (reload_reg |=>
    o_dual_proto == (!$past(nv_reg[NV_DUAL_BIT]) && $past(nv_reg[NV_QUAD_BIT])))
    else $error("two-line protocol not loaded");
  a_reload_wrap: assert property (reload_reg |=>
    o_vol_value[VOL_WRAP_LSB +: 2] == WRAP_CONT)
    else $error("runtime wrap not restored");
  a_settings_steady: assert property (!reload_reg |=>
    $stable(o_dtr_en) && $stable(o_data_line_three_hold_en) &&
    $stable(o_quad_proto) && $stable(o_dual_proto))
    else $error("protocol settings moved outside reload");
  a_layout_steady: assert property (!reload_reg |=>
    $stable(o_addr_4byte) && $stable(o_segment) &&
    $stable(o_drive_code) && $stable(o_xip_mode))
    else $error("address or drive settings moved outside reload");
  a_vol_steady: assert property (!reload_reg && !vol_wr |=>
    $stable(o_vol_value))
    else $error("runtime value moved without a write");
  a_nv_store: assert property (nv_wr |=>
    o_nv_value == $past(wr_data))
    else $error("persistent write not stored");
  a_nv_steady: assert property (!nv_wr |=>
    $stable(o_nv_value))
    else $error("persistent value moved without a write");
  c_nv_write: cover property (nv_wr);
  c_vol_write: cover property (vol_wr);
  c_wrap_turn: cover property (i_rd_next && !wrap_cont && ((rd_addr_reg & mask) == mask));
  c_quad_over_dual: cover property (o_quad_proto && !dual_n_reg);
  c_four_byte_start: cover property (i_rd_start && o_addr_4byte);
endmodule : flash_config_registers

//--- flash_host_model.sv
// Purpose: behavioural serial host that frames register commands
// Assumes: mode 0 link, 80 ns period, clock still between frames
// Notes: released data line shows the inverse of its last bit
module flash_host_model (
  output logic o_sclk, // link clock to device
  output logic o_cs_n, // frame select, active low
  output logic o_dq0, // serial data to device
  input wire logic i_dq1, // serial data from device
  input wire logic i_dq1_oe // device drives i_dq1
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq0 = 1'b0;
  end
  // ****************
  // one frame: opcode, then nb bits msb first
  // ****************
  // read bits taken while the device is not driving become x, so they never match
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int nb,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {op, wd};
    rd = 16'h0000;
    #0.7;
    o_cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      o_dq0 = sh[23-i];
      #20;
      if (i >= 8) rd = {rd[14:0], (i_dq1_oe === 1'b1) ? i_dq1 : 1'bx};
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
      #20;
    end
    o_cs_n = 1'b1;
    o_dq0 = ~o_dq0;
    #100;
  endtask : xfer
endmodule : flash_host_model

//--- flash_config_registers_tb_top.sv
// Purpose: self-checking bench for the flash configuration registers
// Assumes: host model frames commands on an 80 ns link clock
// Notes: warm resets pulse the device reset alone
module flash_config_registers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_cfg_pkg::*;
  logic clk, nrst, por_n, rs, rn;
  logic [ADDR_W-1:0] ra, ca;
  wire logic sclk, cs_n, dq0, dq1, oe;
  logic [3:0] dc;
  logic dd, xa, dtr, hold, quad, dual, a4, dv;
  logic [2:0] xm, dcode, seg;
  logic [NV_W-1:0] nv;
  logic [VOL_W-1:0] vol;
  logic [14:0] wk;
  logic [15:0] rd;
  int n_mismatch, cmp_count;
  assign wk = {dtr, hold, quad, dual, a4, seg, xm, dcode, dv};
  flash_config_registers dut_u (
    .i_core_clk(clk), .i_nrst(nrst), .i_por_n(por_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_dq0(dq0), .o_dq1(dq1), .o_dq1_oe(oe), .i_rd_start(rs), .i_rd_addr(ra),
    .i_rd_next(rn), .o_rd_addr(ca), .o_dummy_cycles(dc), .o_dummy_default(dd),
    .o_xip_active(xa), .o_xip_mode(xm), .o_drive_code(dcode), .o_drive_valid(dv),
    .o_dtr_en(dtr), .o_data_line_three_hold_en(hold), .o_quad_proto(quad),
    .o_dual_proto(dual), .o_addr_4byte(a4), .o_segment(seg), .o_nv_value(nv),
    .o_vol_value(vol));
  flash_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_dq0(dq0), .i_dq1(dq1),
    .i_dq1_oe(oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************
  // helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic warm_reset;
    cyc(1);
    nrst = 1'b0;
    cyc(20);
    nrst = 1'b1;
    cyc(5);
  endtask : warm_reset
  task automatic wv(input logic [7:0] v);
    host_u.xfer(OP_WR_VOL, {v, 8'h00}, 8, rd);
    cyc(2);
  endtask : wv
  function automatic logic [26:0] nxt(input logic [26:0] a, input logic [1:0] w);
    logic [26:0] m;
    m = (w == 2'h3) ? '1 : (27'h10 << w) - 27'h1;
    return (a & ~m) | ((a + 27'h1) & m);
  endfunction : nxt
  // ****************
  // scenarios
  // ****************
  task automatic t_power_on;
    chk("working", wk, {5'b01000, 3'h0, 3'h0, 3'h7, 1'b1});
    chk("dummy", {dd, dc, xa}, {1'b1, 4'h8, 1'b0});
    chk("stores", {nv, vol}, {16'hFFFF, 8'hFB});
    host_u.xfer(OP_RD_NV, 16'h0000, 16, rd);
    chk("nv read", rd, 16'hFFFF);
    host_u.xfer(OP_RD_VOL, 16'h0000, 8, rd);
    chk("vol read", rd, 16'h00FB);
  endtask : t_power_on
  task automatic t_vol_write;
    wv(8'hE4);
    chk("vol", vol, 8'hE0);
    chk("dummy", {dd, dc, xa}, {1'b0, 4'hE, 1'b1});
    chk("working", wk, {5'b01000, 3'h0, 3'h0, 3'h7, 1'b1});
    wv(8'hF7);
    chk("dummy", {dd, dc, xa}, {1'b1, 4'h8, 1'b1});
    host_u.xfer(OP_RD_VOL, 16'h0000, 8, rd);
    chk("vol read", rd, 16'h00F3);
  endtask : t_vol_write
  task automatic t_refusals;
    host_u.xfer(8'h00, 16'h1234, 16, rd);
    host_u.xfer(OP_WR_NV, 16'hABCD, 8, rd);
    host_u.xfer(OP_WR_VOL, 16'h0000, 4, rd);
    chk("stores", {nv, vol}, {16'hFFFF, 8'hF3});
  endtask : t_refusals
  task automatic t_nv_program;
    host_u.xfer(OP_WR_NV, 16'h54C8, 16, rd);
    cyc(2);
    chk("nv", nv, 16'h54C8);
    chk("working held", wk, {5'b01000, 3'h0, 3'h0, 3'h7, 1'b1});
    host_u.xfer(OP_RD_NV, 16'h0000, 16, rd);
    chk("nv read", rd, 16'h54C8);
    warm_reset();
    chk("nv kept", nv, 16'h54C8);
    chk("working", wk, {5'b10011, 3'h7, 3'h2, 3'h3, 1'b1});
    chk("dummy", {dd, dc, xa}, {1'b0, 4'h5, 1'b1});
    chk("vol reload", vol, 8'h53);
    rs = 1'b1;
    ra = 27'h512_3456;
    cyc(1);
    rs = 1'b0;
    chk("full addr", ca, 27'h512_3456);
  endtask : t_nv_program
  task automatic t_priority;
    host_u.xfer(OP_WR_NV, 16'h0001, 16, rd);
    warm_reset();
    chk("working", wk, {5'b10100, 3'h7, 3'h0, 3'h0, 1'b0});
    chk("dummy", {dd, dc, xa}, {1'b1, 4'h8, 1'b1});
    chk("vol reload", vol, 8'h03);
    rs = 1'b1;
    ra = 27'h012_3456;
    cyc(1);
    rs = 1'b0;
    chk("segment addr", ca, 27'h712_3456);
  endtask : t_priority
  task automatic t_wrap;
    logic [26:0] e;
    for (int w = 0; w < 4; w++) begin
      wv({4'h1, 2'b10, w[1:0]});
      chk("dummy", {dd, dc, xa}, {1'b0, 4'h1, 1'b0});
      e = 27'h700_003D;
      rs = 1'b1;
      rn = 1'b1;
      ra = e;
      cyc(1);
      rs = 1'b0;
      chk("start", ca, e);
      repeat (5) begin
        cyc(1);
        e = nxt(e, w[1:0]);
        chk("next", ca, e);
      end
      rn = 1'b0;
    end
  endtask : t_wrap
  initial begin
    nrst = 1'b0;
    por_n = 1'b0;
    rs = 1'b0;
    rn = 1'b0;
    ra = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cyc(20);
    nrst = 1'b1;
    por_n = 1'b1;
    cyc(5);
    t_power_on();
    t_vol_write();
    t_refusals();
    t_nv_program();
    t_priority();
    t_wrap();
    complete_run();
  end
  // about four times the expected run
  initial begin
    #100_000;
    n_mismatch++;
    complete_run();
  end
endmodule : flash_config_registers_tb_top
